// ### common/sld_pkg.sv
/*
 * shared constants of the segment panel scan driver: register offsets,
 * field positions, reset values, level codes and clock divide figures.
 * assumes a 32-bit classic wishbone register port.
 */
package sld_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CTRL1_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] IEN_OFS = 8'h0c;
   localparam logic [7:0] ICLR_OFS = 8'h10;
   localparam logic [7:0] DOT_OFS = 8'h20;
   // control and interrupt field positions
   localparam int EN_BIT = 0;
   localparam int TYPE_LSB = 1;
   localparam int BIAS_BIT = 3;
   localparam int MID_BIT = 5;
   localparam int UPPER_BIT = 6;
   localparam int DUTY_LSB = 8;
   localparam int SRC_BIT = 10;
   localparam int RATE_BIT = 11;
   localparam int DRIVE_LSB = 28;
   localparam int REF_LSB = 0;
   localparam int PUMP_LSB = 4;
   localparam int FRAME_BIT = 0;
   // reset values and writable masks
   localparam logic [31:0] CTRL_RST = 32'h1000_0302;
   localparam logic [31:0] CTRL_WMASK = 32'h3fff_ffff;
   localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL1_WMASK = 32'h0000_00f3;
   // supply structure codes
   localparam logic [1:0] TYPE_LADDER = 2'h0;
   localparam logic [1:0] TYPE_PUMP_A = 2'h1;
   localparam logic [1:0] TYPE_PUMP_B = 2'h2;
   // duty codes
   localparam logic [1:0] DUTY_HALF = 2'h1;
   localparam logic [1:0] DUTY_THIRD = 2'h2;
   localparam logic [1:0] DUTY_QUARTER = 2'h3;
   // pin drive level codes
   localparam logic [1:0] LVL_VSS = 2'h0;
   localparam logic [1:0] LVL_V2 = 2'h1;
   localparam logic [1:0] LVL_V3 = 2'h2;
   localparam logic [1:0] LVL_VLCD = 2'h3;
   // matrix and scan clock figures
   localparam int N_COM = 4;
   localparam int N_SEG = 32;
   localparam int N_LOW_SEG = 12;
   localparam int MID_TOP = 23;
   localparam int DIV_FAST = 64;
   localparam int DIV_SLOW = 128;
endpackage

// ### rtl/sld_scan_div.sv
/*
 * scan clock divider: picks one of two slow source tick streams and
 * divides it by 64 or 128 into a one-cycle scan tick.
 * assumes source ticks are one-cycle pulses synchronous to clk_i.
 */
`timescale 1ns/1ps
module sld_scan_div #(
   parameter int CNT_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic src_sel_i,
   input wire logic div_sel_i,
   input wire logic int_tick_i,
   input wire logic ext_tick_i,
   output logic tick_o
);
   if ((2 ** CNT_W) < sld_pkg::DIV_SLOW) begin : g_bad_width
      $error("sld_scan_div: CNT_W too small");
   end

   logic [CNT_W-1:0] cnt_ff;
   logic src_tick;
   logic [CNT_W-1:0] last;

   assign src_tick = src_sel_i ? ext_tick_i : int_tick_i;
   assign last = div_sel_i ? CNT_W'(sld_pkg::DIV_SLOW - 1) : CNT_W'(sld_pkg::DIV_FAST - 1);

   // source select and 64/128 divide
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_ff <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (src_tick) begin
            if (cnt_ff >= last) begin
               cnt_ff <= '0;
               tick_o <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
      end
   end

   tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_o |=> !tick_o)
      else $error("scan tick longer than one cycle");
endmodule

// ### rtl/sld_scan_driver.sv
/*
 * segment panel scan driver: wishbone registers, frame interrupt, pin
 * handover from gpio, common/segment scan sequencer and level coding.
 * assumes synchronous slow source ticks and a passive glass panel.
 */
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sld_scan_driver (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic slow_int_tick_i,
   input wire logic slow_ext_tick_i,
   output logic scan_clock_o,
   output logic [3:0] common_line_lcd_o,
   output logic [31:0] segment_line_lcd_o,
   output logic bias_pins_lcd_o,
   output logic pump_cap_pins_lcd_o,
   output logic ladder_on_o,
   output logic pump_on_o,
   output logic [1:0] ladder_ref_o,
   output logic [3:0] pump_level_select_o,
   output logic half_bias_o,
   output logic [1:0] drive_strength_o,
   output logic [7:0] common_line_level_o,
   output logic [63:0] segment_line_level_o
);
   ////////////////////////////////////////////////////////////////////
   // functions
   function automatic logic [31:0] merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] sel, input logic [31:0] msk);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r & msk;
   endfunction

   // common level: selected drives outer rails, others the inner ones
   function automatic logic [1:0] com_lvl(input logic hit, input logic pol,
         input logic half);
      if (hit) begin
         return pol ? sld_pkg::LVL_VLCD : sld_pkg::LVL_VSS;
      end else if (half) begin
         return sld_pkg::LVL_V2;
      end
      return pol ? sld_pkg::LVL_V2 : sld_pkg::LVL_V3;
   endfunction

   function automatic logic [1:0] seg_lvl(input logic on, input logic pol,
         input logic half);
      if (on) begin
         return pol ? sld_pkg::LVL_VSS : sld_pkg::LVL_VLCD;
      end else if (half) begin
         return pol ? sld_pkg::LVL_VLCD : sld_pkg::LVL_VSS;
      end
      return pol ? sld_pkg::LVL_V3 : sld_pkg::LVL_V2;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // register bus
   logic [31:0] ctrl_ff;
   logic [31:0] ctrl1_ff;
   logic [31:0] dot_ff [sld_pkg::N_COM];
   logic [0:0] stat_ff;
   logic [0:0] ien_ff;
   logic req;
   logic wr;
   logic frame_ev;
   logic clr_frame;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign clr_frame = wr && (wb_adr_i == sld_pkg::ICLR_OFS) && wb_sel_i[0]
      && wb_dat_i[sld_pkg::FRAME_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= sld_pkg::CTRL_RST;
         ctrl1_ff <= sld_pkg::CTRL1_RST;
         ien_ff <= '0;
      end else if (wr) begin
         case (wb_adr_i)
            sld_pkg::CTRL_OFS: begin
               ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i, sld_pkg::CTRL_WMASK);
            end
            sld_pkg::CTRL1_OFS: begin
               ctrl1_ff <= merge(ctrl1_ff, wb_dat_i, wb_sel_i, sld_pkg::CTRL1_WMASK);
            end
            sld_pkg::IEN_OFS: begin
               if (wb_sel_i[0]) begin
                  ien_ff <= wb_dat_i[0:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // one dot word per common, bit n is segment n
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < sld_pkg::N_COM; c++) begin
            dot_ff[c] <= '0;
         end
      end else if (wr) begin
         for (int c = 0; c < sld_pkg::N_COM; c++) begin
            if (wb_adr_i == sld_pkg::DOT_OFS + 8'(4 * c)) begin
               dot_ff[c] <= merge(dot_ff[c], wb_dat_i, wb_sel_i, 32'hffff_ffff);
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            sld_pkg::CTRL_OFS: wb_dat_o <= ctrl_ff;
            sld_pkg::CTRL1_OFS: wb_dat_o <= ctrl1_ff;
            sld_pkg::STAT_OFS: wb_dat_o <= {31'h0, stat_ff};
            sld_pkg::IEN_OFS: wb_dat_o <= {31'h0, ien_ff};
            sld_pkg::DOT_OFS: wb_dat_o <= dot_ff[0];
            sld_pkg::DOT_OFS + 8'h04: wb_dat_o <= dot_ff[1];
            sld_pkg::DOT_OFS + 8'h08: wb_dat_o <= dot_ff[2];
            sld_pkg::DOT_OFS + 8'h0c: wb_dat_o <= dot_ff[3];
            default: wb_dat_o <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame interrupt
   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_ff <= '0;
      end else if (frame_ev) begin
         stat_ff <= 1'b1;
      end else if (clr_frame) begin
         stat_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_ff & ien_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control decode
   logic en;
   logic [1:0] typ;
   logic [1:0] duty;
   logic ladder;
   logic pump;
   logic run;
   logic half;
   logic [1:0] last_com;

   assign en = ctrl_ff[sld_pkg::EN_BIT];
   assign typ = ctrl_ff[sld_pkg::TYPE_LSB +: 2];
   assign duty = ctrl_ff[sld_pkg::DUTY_LSB +: 2];
   assign half = ctrl_ff[sld_pkg::BIAS_BIT];
   assign ladder = en && (typ == sld_pkg::TYPE_LADDER);
   assign pump = en && (typ == sld_pkg::TYPE_PUMP_A || typ == sld_pkg::TYPE_PUMP_B);
   // reserved duty code or supply type keeps the sequencer idle
   assign run = (ladder || pump) && (duty != 2'h0);
   assign last_com = duty;

   ////////////////////////////////////////////////////////////////////
   // scan clock and sequencer
   logic tick;

   sld_scan_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .src_sel_i(ctrl_ff[sld_pkg::SRC_BIT]),
      .div_sel_i(ctrl_ff[sld_pkg::RATE_BIT]),
      .int_tick_i(slow_int_tick_i),
      .ext_tick_i(slow_ext_tick_i),
      .tick_o(tick)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_clock_o <= 1'b0;
      end else begin
         scan_clock_o <= tick;
      end
   end

   typedef enum logic [0:0] {SLD_IDLE, SLD_SCAN} sld_state_t;
   sld_state_t state_ff;
   logic [1:0] com_ff;
   logic pol_ff;

   // frame ends after duty+1 scan ticks
   assign frame_ev = (state_ff == SLD_SCAN) && tick && (com_ff == last_com);

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         state_ff <= SLD_IDLE;
         com_ff <= '0;
         pol_ff <= 1'b0;
      end else begin
         case (state_ff)
            SLD_IDLE: begin
               state_ff <= SLD_SCAN;
            end
            SLD_SCAN: begin
               // duty shrunk under a live scan: restart the frame
               if (com_ff > last_com) begin
                  com_ff <= '0;
               end else if (tick) begin
                  if (com_ff >= last_com) begin
                     com_ff <= '0;
                     pol_ff <= !pol_ff;
                  end else begin
                     com_ff <= com_ff + 1'b1;
                  end
               end
            end
            default: begin
               state_ff <= SLD_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin handover and supply controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         common_line_lcd_o <= '0;
         segment_line_lcd_o <= '0;
         bias_pins_lcd_o <= 1'b0;
         pump_cap_pins_lcd_o <= 1'b0;
         ladder_on_o <= 1'b0;
         pump_on_o <= 1'b0;
      end else begin
         for (int c = 0; c < sld_pkg::N_COM; c++) begin
            // ladder follows duty, pump takes all four
            common_line_lcd_o[c] <= pump || (ladder && (duty != 2'h0)
               && (2'(c) <= last_com));
         end
         for (int s = 0; s < sld_pkg::N_SEG; s++) begin
            if (s < sld_pkg::N_LOW_SEG) begin
               segment_line_lcd_o[s] <= ladder || pump;
            end else if (s <= sld_pkg::MID_TOP) begin
               segment_line_lcd_o[s] <= (ladder || pump)
                  && ctrl_ff[sld_pkg::MID_BIT];
            end else begin
               segment_line_lcd_o[s] <= (ladder || pump)
                  && ctrl_ff[sld_pkg::UPPER_BIT];
            end
         end
         bias_pins_lcd_o <= ladder || pump;
         pump_cap_pins_lcd_o <= pump;
         ladder_on_o <= ladder;
         pump_on_o <= pump;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ladder_ref_o <= '0;
         pump_level_select_o <= '0;
         half_bias_o <= 1'b0;
         drive_strength_o <= '0;
      end else begin
         ladder_ref_o <= ctrl1_ff[sld_pkg::REF_LSB +: 2];
         pump_level_select_o <= ctrl1_ff[sld_pkg::PUMP_LSB +: 4];
         half_bias_o <= half;
         drive_strength_o <= ctrl_ff[sld_pkg::DRIVE_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // drive level coding
   logic [7:0] nxt_com_lvl;
   logic [63:0] nxt_seg_lvl;
   genvar gc;
   genvar gs;
   generate
      for (gc = 0; gc < sld_pkg::N_COM; gc++) begin : g_com
         assign nxt_com_lvl[2*gc +: 2] = (2'(gc) > last_com) ? sld_pkg::LVL_VSS
            : com_lvl(com_ff == 2'(gc), pol_ff, half);
      end
      for (gs = 0; gs < sld_pkg::N_SEG; gs++) begin : g_seg
         assign nxt_seg_lvl[2*gs +: 2] = seg_lvl(dot_ff[com_ff][gs], pol_ff, half);
      end
   endgenerate

   // one process owns all level flops
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != SLD_SCAN) begin
         common_line_level_o <= '0;
         segment_line_level_o <= '0;
      end else begin
         common_line_level_o <= nxt_com_lvl;
         segment_line_level_o <= nxt_seg_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   ack_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   frame_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_ev |=> stat_ff[0] ##1 (irq_o == $past(ien_ff[0])))
      else $error("frame event not latched");

   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (stat_ff[0] && ien_ff[0]) |=> irq_o)
      else $error("enabled flag did not raise irq");

   frame_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_ev && run |=> com_ff == 2'h0 && pol_ff != $past(pol_ff))
      else $error("frame did not wrap to first common");

   com_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_ff == SLD_SCAN && $stable(duty) |-> com_ff <= last_com)
      else $error("common index beyond duty");

   off_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !en ##1 !en |-> common_line_lcd_o == 4'h0 && segment_line_lcd_o == 32'h0)
      else $error("pins still lcd while disabled");

   mid_group_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_ff[sld_pkg::MID_BIT] |=> segment_line_lcd_o[23:12] == 12'h0)
      else $error("middle segments handed without enable");

   upper_group_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_ff[sld_pkg::UPPER_BIT] |=> segment_line_lcd_o[31:24] == 8'h0)
      else $error("upper segments handed without enable");

   pump_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pump |=> pump_cap_pins_lcd_o && common_line_lcd_o == 4'hf && bias_pins_lcd_o)
      else $error("pump type pins not handed over");

   ladder_com_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ladder && duty == sld_pkg::DUTY_HALF |=> common_line_lcd_o == 4'h3
      && !pump_cap_pins_lcd_o)
      else $error("ladder commons wrong for half duty");

   frame_cov: cover property (@(posedge clk_i) disable iff (rst_i) frame_ev);
   clr_race_cov: cover property (@(posedge clk_i) disable iff (rst_i)
      frame_ev && clr_frame);
   third_duty_cov: cover property (@(posedge clk_i) disable iff (rst_i)
      frame_ev && duty == sld_pkg::DUTY_THIRD);
   irq_cov: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

// ### verification/sld_panel_model.sv
/*
 * passive glass panel model: finds the single selected common from the
 * drive levels and reports which segments of that row are lit.
 * assumes the driver level coding of the shared package.
 */
`timescale 1ns/1ps
module sld_panel_model (
   input wire logic [3:0] com_lcd_i,
   input wire logic [31:0] seg_lcd_i,
   input wire logic [7:0] com_lvl_i,
   input wire logic [63:0] seg_lvl_i,
   output logic one_sel_o,
   output logic [1:0] com_o,
   output logic [31:0] lit_o
);
   logic [1:0] cl;
   int n;
   // a dot lights only across full swing, selected common against opposite segment
   always_comb begin
      n = 0;
      com_o = 2'h0;
      for (int c = 0; c < 4; c++) begin
         cl = com_lvl_i[2*c +: 2];
         if (com_lcd_i[c] && (cl == sld_pkg::LVL_VSS || cl == sld_pkg::LVL_VLCD)) begin
            n++;
            com_o = 2'(c);
         end
      end
      cl = com_lvl_i[2*com_o +: 2];
      for (int s = 0; s < 32; s++) begin
         lit_o[s] = seg_lcd_i[s] && (seg_lvl_i[2*s +: 2] == ~cl);
      end
      one_sel_o = (n == 1);
   end
endmodule

// ### verification/sld_scan_driver_tb.sv
/*
 * self-checking bench of the scan driver: register port, pin handover,
 * frame timing, frame interrupt and lit dots seen by the panel model.
 * assumes slow source ticks may be driven every cycle.
 */
`timescale 1ns/1ps
module sld_scan_driver_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, irq_o, scan_clock_o, bias_pins_lcd_o, pump_cap_pins_lcd_o;
   logic slow_int_tick_i = 1'b0, slow_ext_tick_i = 1'b0;
   logic [3:0] common_line_lcd_o, pump_level_select_o;
   logic [31:0] segment_line_lcd_o, pan_lit;
   logic ladder_on_o, pump_on_o, half_bias_o, pan_one, irq_q;
   logic [1:0] ladder_ref_o, drive_strength_o, pan_com;
   logic [7:0] common_line_level_o;
   logic [63:0] segment_line_level_o;
   logic [31:0] rq[$], dots[4], v;
   logic pan_chk = 1'b0, src_s = 1'b0, tick_en = 1'b0;
   int bad_count = 0, check_count = 0, cyc_n = 0;
   int gap = 0, since = 0, pls = 0, npls = 0, rises = 0;

   sld_scan_driver u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .slow_int_tick_i,
      .slow_ext_tick_i, .scan_clock_o, .common_line_lcd_o, .segment_line_lcd_o,
      .bias_pins_lcd_o, .pump_cap_pins_lcd_o, .ladder_on_o, .pump_on_o, .ladder_ref_o,
      .pump_level_select_o, .half_bias_o, .drive_strength_o, .common_line_level_o,
      .segment_line_level_o);
   sld_panel_model u_pan (.com_lcd_i(common_line_lcd_o), .seg_lcd_i(segment_line_lcd_o),
      .com_lvl_i(common_line_level_o), .seg_lvl_i(segment_line_level_o),
      .one_sel_o(pan_one), .com_o(pan_com), .lit_o(pan_lit));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 64);
      if (n >= 64) bad_count++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic st;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic wait_rises(input int k);
      int n;
      n = 0;
      while (rises < k && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000) bad_count++;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // read results, frame meter, panel rows
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && !wb_we_i) begin
         if (rq.size() == 0) bad_count++;
         else chk_val(wb_dat_o, rq.pop_front());
      end
      irq_q <= irq_o;
      if (irq_o === 1'b1 && irq_q === 1'b0) begin
         gap <= since;
         since <= 1;
         npls <= pls;
         pls <= int'(scan_clock_o);
         rises <= rises + 1;
      end else begin
         since <= since + 1;
         pls <= pls + int'(scan_clock_o);
      end
      if (pan_chk && pan_one === 1'b1) chk_val(pan_lit, dots[pan_com]);
      slow_int_tick_i <= tick_en & ~src_s;
      slow_ext_tick_i <= tick_en & src_s;
   end

   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic pmp, m, u, b, s, r;
      logic [1:0] d;
      void'($urandom(32'h8a6b5562));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk_val({common_line_lcd_o, segment_line_lcd_o, bias_pins_lcd_o, irq_o}, 0);
      rd(sld_pkg::CTRL_OFS, sld_pkg::CTRL_RST);
      rd(sld_pkg::CTRL1_OFS, 32'h0);
      wb(1'b1, 8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      v = $urandom & sld_pkg::CTRL1_WMASK;
      wb(1'b1, sld_pkg::CTRL1_OFS, v);
      rd(sld_pkg::CTRL1_OFS, v);
      st();
      chk_val({ladder_ref_o, pump_level_select_o, drive_strength_o}, {v[1:0], v[7:4],
         sld_pkg::CTRL_RST[sld_pkg::DRIVE_LSB +: 2]});
      $display("registers done");
      for (int t = 0; t < 3; t++) begin
         for (int k = 1; k < 4; k++) begin
            {m, u, b} = 3'($urandom);
            d = 2'(k);
            pmp = (t != 0);
            v = {20'h0, 2'h0, d, 1'b0, u, m, 1'b0, b, 2'(t), 1'b1};
            wb(1'b1, sld_pkg::CTRL_OFS, v);
            st();
            chk_val({common_line_lcd_o, segment_line_lcd_o}, {pmp ? 4'hf : 4'((1 << (k + 1)) - 1),
               {8{u}}, {12{m}}, 12'hfff});
            chk_val({bias_pins_lcd_o, pump_cap_pins_lcd_o, ladder_on_o, pump_on_o, half_bias_o},
               {1'b1, pmp, ~pmp, pmp, b});
         end
      end
      wb(1'b1, sld_pkg::CTRL_OFS, 32'h0);
      st();
      chk_val({common_line_lcd_o, segment_line_lcd_o, ladder_on_o, pump_on_o}, 0);
      $display("pin handover done");
      for (int c = 0; c < 4; c++) begin
         dots[c] = $urandom;
         wb(1'b1, 8'(sld_pkg::DOT_OFS + 8'(4 * c)), dots[c]);
      end
      rd(sld_pkg::DOT_OFS, dots[0]);
      tick_en <= 1'b1;
      wb(1'b1, sld_pkg::IEN_OFS, 32'h0);
      wb(1'b1, sld_pkg::ICLR_OFS, 32'h1);
      wb(1'b1, sld_pkg::CTRL_OFS, 32'h0000_0361);
      st();
      pan_chk <= 1'b1;
      repeat (264) @(posedge clk_i);
      chk_val(irq_o, 1'b0);
      rd(sld_pkg::STAT_OFS, 32'h1);
      wb(1'b1, sld_pkg::IEN_OFS, 32'h1);
      st();
      chk_val(irq_o, 1'b1);
      wb(1'b1, sld_pkg::ICLR_OFS, 32'h1);
      st();
      chk_val(irq_o, 1'b0);
      $display("interrupt done");
      for (int k = 0; k < 5; k++) begin
         {s, r, b} = 3'($urandom);
         d = 2'($urandom_range(1, 3));
         pan_chk <= 1'b0;
         src_s <= s;
         wb(1'b1, sld_pkg::CTRL_OFS, 32'h0);
         wb(1'b1, sld_pkg::CTRL_OFS, {20'h0, r, s, d, 3'b011, 1'b0, b, 3'b001});
         wb(1'b1, sld_pkg::ICLR_OFS, 32'h1);
         st();
         pan_chk <= 1'b1;
         wait_rises(rises + 1);
         wb(1'b1, sld_pkg::ICLR_OFS, 32'h1);
         wait_rises(rises + 1);
         #1;
         chk_val(gap, (d + 1) * (r ? 128 : 64));
         chk_val(npls, d + 1);
         wb(1'b1, sld_pkg::ICLR_OFS, 32'h1);
         $display("frame run %0d done", k);
      end
      wrap_up();
   end
endmodule
